//--- design/tecc_defines.svh
/*
 * Register offsets, field positions, reset values and constants of the
 * timer/event counter with compare.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef TECC_DEFINES_SVH
`define TECC_DEFINES_SVH

`define TECC_OFS_CTRL    4'h0
`define TECC_OFS_CNT     4'h4
`define TECC_OFS_CCF     4'h8
`define TECC_OFS_CCS     4'hC
`define TECC_AW          4

`define TECC_CTRL_MODE_LO   0
`define TECC_CTRL_MODE_HI   1
`define TECC_CTRL_CCF_CAP   2
`define TECC_CTRL_EDGE_SRC  3
`define TECC_CTRL_PIN_OUT   4
`define TECC_CTRL_IRQ_MASK0 8
`define TECC_CTRL_IRQ_MASK1 9
`define TECC_CTRL_STAT0     16
`define TECC_CTRL_STAT1     17

`define TECC_CNT_MAX     16'hFFFF
`define TECC_CNT_ZERO    16'h0000
`define TECC_CTRL_RST    32'h0000_0000

`endif

//--- design/tecc_pkg.sv
/*
 * Types of the timer/event counter with compare.
 * Assumes the defines header is compiled alongside.
 */
`default_nettype none
package tecc_pkg;
    typedef enum logic [1:0] {
        TECC_STOP     = 2'b00,
        TECC_FREE     = 2'b01,
        TECC_CLR_EDGE = 2'b10,
        TECC_CLR_MTCH = 2'b11
    } tecc_mode_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [3:0]  adr;
        logic [31:0] dat;
    } tecc_wb_req_t;

    typedef enum logic [1:0] {
        TECC_IDLE = 2'b01,
        TECC_ACK  = 2'b10
    } tecc_bus_st_t;
endpackage
`default_nettype wire

//--- design/tecc_sync.sv
/*
 * Two-stage synchroniser with rising edge pulse for an external pin.
 * Assumes the pin is asynchronous to clk_i.
 */
`default_nettype none
module tecc_sync (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    output logic      lvl_o,
    output logic      rise_o
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign lvl_o  = sync_q;
    assign rise_o = sync_q & ~prev_q;
endmodule
`default_nettype wire

//--- design/tecc_top.sv
/*
 * Sixteen-bit timer/event counter with one capture/compare register, one capture register, a Wishbone
 * classic slave, sticky status with mask and one level interrupt.
 * Assumes a single 100 MHz clock; edge inputs are asynchronous pins.
 */
`include "tecc_defines.svh"
`default_nettype none
module tecc_top (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  cyc_i,
    input  wire logic                  stb_i,
    input  wire logic                  we_i,
    input  wire logic [3:0]            sel_i,
    input  wire logic [`TECC_AW-1:0]   adr_i,
    input  wire logic [31:0]           dat_i,
    output logic [31:0]                dat_o,
    output logic                       ack_o,
    input  wire logic                  edge_input_first_i,
    input  wire logic                  shared_port_pin_i,
    output logic                       shared_port_pin_o,
    output logic                       shared_port_pin_oe_o,
    output logic                       irq_o
);
    import tecc_pkg::*;

    tecc_wb_req_t  req;
    tecc_bus_st_t  bus_q;
    logic [31:0]   ctrl_q;
    logic [15:0]   up_counter_q;
    logic [15:0]   capture_compare_first_q;
    logic [15:0]   capture_compare_second_q;
    logic [15:0]   cnt_d;
    logic          toggle_q;
    logic [1:0]    stat_q;
    logic          in1_rise;
    logic          in2_rise;
    logic          in1_lvl;
    logic          in2_lvl;

    assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i, adr: adr_i, dat: dat_i};

    function automatic logic [31:0] tecc_mask(input logic [3:0] sel);
        tecc_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    function automatic logic [15:0] tecc_step(input logic [15:0] v, input logic clr);
        tecc_step = clr ? `TECC_CNT_ZERO : v + 16'h0001;
    endfunction

    tecc_sync u_sync_first (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pin_i  (edge_input_first_i),
        .lvl_o  (in1_lvl),
        .rise_o (in1_rise)
    );
    tecc_sync u_sync_second (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pin_i  (shared_port_pin_i),
        .lvl_o  (in2_lvl),
        .rise_o (in2_rise)
    );

    // Bus decode.
    wire        bus_req    = req.cyc & req.stb & (bus_q == TECC_IDLE);
    wire        wr_en      = bus_req & req.we;
    wire        rd_en      = bus_req & ~req.we;
    wire        hit_ctrl   = (req.adr == `TECC_OFS_CTRL);
    wire        hit_cnt    = (req.adr == `TECC_OFS_CNT);
    wire        hit_ccf    = (req.adr == `TECC_OFS_CCF);
    wire        hit_ccs    = (req.adr == `TECC_OFS_CCS);
    wire [31:0] wmask      = tecc_mask(req.sel);

    // Control fields.
    wire [1:0]  op_mode      = {ctrl_q[`TECC_CTRL_MODE_HI], ctrl_q[`TECC_CTRL_MODE_LO]};
    wire        running      = (op_mode != 2'b00);
    wire        ccf_capture  = ctrl_q[`TECC_CTRL_CCF_CAP];
    wire        edge_cnt_src = ctrl_q[`TECC_CTRL_EDGE_SRC];
    wire        pin_is_out   = ctrl_q[`TECC_CTRL_PIN_OUT];
    wire [1:0]  irq_mask     = {ctrl_q[`TECC_CTRL_IRQ_MASK1], ctrl_q[`TECC_CTRL_IRQ_MASK0]};

    // A counter read holds the count clock for that cycle; the held tick is paid
    // back on the next cycle, as a double step if that cycle ticks too, so a free-running count loses nothing.
    wire        cnt_read    = rd_en & hit_cnt;
    wire        raw_tick    = edge_cnt_src ? in1_rise : 1'b1;
    logic       pend_q;
    wire        tick        = running & (raw_tick | pend_q) & ~cnt_read;
    wire        dbl_step    = tick & pend_q & raw_tick;
    wire        clr_mtch    = (op_mode == TECC_CLR_MTCH);
    wire        cmp_zero    = (capture_compare_first_q == `TECC_CNT_ZERO);
    wire        cmp_max     = (capture_compare_first_q == `TECC_CNT_MAX);
    wire        at_max      = (up_counter_q == `TECC_CNT_MAX);
    // A zero compare only holds the counter at zero, so no single-pulse count.
    wire        match_clr   = clr_mtch & (up_counter_q == capture_compare_first_q);
    // The second edge input is ignored while the shared pin is an output.
    wire        edge2_valid = in2_rise & ~pin_is_out;
    wire        edge1_valid = in1_rise & ~edge_cnt_src;
    wire        edge_clr    = (op_mode == TECC_CLR_EDGE) & edge1_valid;
    wire        cap_first   = running & ccf_capture & edge2_valid;
    wire        cap_second  = running & edge1_valid;
    wire [15:0] step_one    = tecc_step(up_counter_q, match_clr | edge_clr);
    wire        match_clr2  = clr_mtch & (step_one == capture_compare_first_q);
    wire [15:0] step_two    = tecc_step(step_one, match_clr2);
    // Matching is done on each value reached, the skipped one of a double step too,
    // so a zero compare fires on the step from zero to one, as after a wrap
    // falls out of the plain equality.
    wire [15:0] hit_val     = cmp_zero ? 16'h0001 : capture_compare_first_q;
    wire        hit_two     = dbl_step & (step_two == hit_val);
    wire        hit_first   = tick & ~ccf_capture & ((step_one == hit_val) | hit_two);
    wire        wrap_evt    = tick & cmp_max &
                              (at_max | (dbl_step & (step_one == `TECC_CNT_MAX)));

    assign cnt_d = ~tick ? up_counter_q : (dbl_step ? step_two : step_one);

    wire [1:0] stat_set = {wrap_evt, hit_first};
    wire [1:0] stat_clr = (wr_en & hit_ctrl) ?
                          (dat_i[`TECC_CTRL_STAT1:`TECC_CTRL_STAT0] &
                           {wmask[`TECC_CTRL_STAT1], wmask[`TECC_CTRL_STAT0]}) : 2'b00;

    wire [31:0] ctrl_rd = {14'h0000, stat_q, ctrl_q[15:0]};
    wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd :
                          hit_cnt  ? {16'h0000, up_counter_q} :
                          hit_ccf  ? {16'h0000, capture_compare_first_q} :
                          hit_ccs  ? {16'h0000, capture_compare_second_q} : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_q <= TECC_IDLE;
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            case (bus_q)
                TECC_IDLE: begin
                    if (bus_req) begin
                        bus_q <= TECC_ACK;
                        ack_o <= 1'b1;
                        dat_o <= rd_en ? rd_mux : 32'h0000_0000;
                    end
                end
                TECC_ACK: begin
                    bus_q <= TECC_IDLE;
                    ack_o <= 1'b0;
                end
                default: begin
                    bus_q <= TECC_IDLE;
                    ack_o <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `TECC_CTRL_RST;
        end else if (wr_en & hit_ctrl) begin
            ctrl_q <= {16'h0000, (ctrl_q[15:0] & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0])};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= 2'b00;
        end else begin
            stat_q <= (stat_q & ~stat_clr) | stat_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= running & cnt_read & (raw_tick | pend_q);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            up_counter_q <= `TECC_CNT_ZERO;
        end else if (!running) begin
            up_counter_q <= `TECC_CNT_ZERO;
        end else begin
            up_counter_q <= cnt_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            capture_compare_first_q <= `TECC_CNT_ZERO;
        end else if (cap_first) begin
            capture_compare_first_q <= up_counter_q;
        end else if (wr_en & hit_ccf) begin
            capture_compare_first_q <= dat_i[15:0] & wmask[15:0] |
                                       capture_compare_first_q & ~wmask[15:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            capture_compare_second_q <= `TECC_CNT_ZERO;
        end else if (cap_second) begin
            capture_compare_second_q <= up_counter_q;
        end else if (wr_en & hit_ccs) begin
            capture_compare_second_q <= dat_i[15:0] & wmask[15:0] |
                                        capture_compare_second_q & ~wmask[15:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            toggle_q             <= 1'b0;
            shared_port_pin_o    <= 1'b0;
            shared_port_pin_oe_o <= 1'b0;
            irq_o                <= 1'b0;
        end else begin
            toggle_q             <= toggle_q ^ hit_first;
            shared_port_pin_o    <= toggle_q & pin_is_out;
            shared_port_pin_oe_o <= pin_is_out;
            irq_o                <= |(((stat_q & ~stat_clr) | stat_set) & irq_mask);
        end
    end

    property p_read_no_capture;
        @(posedge clk_i) disable iff (rst_i)
        (cnt_read & ~cap_second) |=> $stable(capture_compare_second_q);
    endproperty
    a_read_no_capture: assert property (p_read_no_capture)
        else $error("counter read changed second register");
    property p_read_holds;
        @(posedge clk_i) disable iff (rst_i)
        (cnt_read & running & ~$past(cnt_read)) |=> (up_counter_q == $past(up_counter_q));
    endproperty
    a_read_holds: assert property (p_read_holds)
        else $error("counter moved during read");
    sequence s_read_then_free;
        cnt_read & running & ~edge_cnt_src & ~match_clr ##1 ~cnt_read & running & ~edge_clr;
    endsequence
    property p_read_resume;
        @(posedge clk_i) disable iff (rst_i)
        s_read_then_free |=> (up_counter_q != $past(up_counter_q, 2));
    endproperty
    a_read_resume: assert property (p_read_resume)
        else $error("count not resumed after read");
    property p_zero_hold;
        @(posedge clk_i) disable iff (rst_i)
        (clr_mtch & cmp_zero & (up_counter_q == 16'h0000)) |=> (up_counter_q == 16'h0000);
    endproperty
    a_zero_hold: assert property (p_zero_hold) else $error("zero compare counted");
    property p_stop;
        @(posedge clk_i) disable iff (rst_i) !running |=> (up_counter_q == 16'h0000);
    endproperty
    a_stop: assert property (p_stop) else $error("counter not held when stopped");
    property p_match_clear;
        @(posedge clk_i) disable iff (rst_i)
        (tick & match_clr & ~dbl_step) |=> (up_counter_q == 16'h0000);
    endproperty
    a_match_clear: assert property (p_match_clear) else $error("no clear on match");
    property p_zero_cmp;
        @(posedge clk_i) disable iff (rst_i)
        (tick & ~ccf_capture & ~match_clr & ~edge_clr & (up_counter_q == 16'h0000)
         & (capture_compare_first_q == 16'h0000)) |=> stat_q[0];
    endproperty
    a_zero_cmp: assert property (p_zero_cmp) else $error("zero compare missed");
    property p_wrap;
        @(posedge clk_i) disable iff (rst_i) wrap_evt |=> stat_q[1];
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap flag not set");
    property p_cap_mode;
        @(posedge clk_i) disable iff (rst_i)
        (~ccf_capture & ~(wr_en & hit_ccf)) |=> $stable(capture_compare_first_q);
    endproperty
    a_cap_mode: assert property (p_cap_mode) else $error("compare value captured");
    property p_pin_excl;
        @(posedge clk_i) disable iff (rst_i) shared_port_pin_oe_o |-> ~cap_first;
    endproperty
    a_pin_excl: assert property (p_pin_excl) else $error("pin used both ways");
endmodule
`default_nettype wire

//--- bench/tecc_pins.sv
/*
 * Board-side model of the two timer input pins, driving clean edge pulses.
 * Assumes the bench calls its task from a process synchronous to clk_i.
 */
`default_nettype none
module tecc_pins (
    input  wire logic clk_i,
    output logic      edge_first_o,
    output logic      shared_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        edge_first_o = 1'b0;
        shared_o     = 1'b0;
    end

    // Four cycles high, so the two-flop synchroniser cannot miss a pulse.
    task automatic pulse(input logic on_shared);
        @(posedge clk_i);
        if (on_shared) shared_o <= 1'b1;
        else edge_first_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        shared_o     <= 1'b0;
        edge_first_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- bench/timer_event_counter_compare_test.sv
/*
 * Self-checking bench of the timer/event counter: Wishbone driver, queued
 * read expectations checked by a monitor, pin model on the edge inputs.
 * Assumes the design files and defines header are compiled first.
 */
`include "tecc_defines.svh"
`default_nettype none
module timer_event_counter_compare_test;
    timeunit 1ns;
    timeprecision 1ns;
    import tecc_pkg::*;
    typedef struct packed {logic [31:0] exp; logic [31:0] msk;} tecc_note_t;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc, stb, we, ack_o, pin_o, oe, irq, edge1, shr, shared_w;
    logic [3:0]  adr;
    logic [31:0] wdat, dat_o, last, c0, c1, cv;
    tecc_note_t  notes[$];
    tecc_note_t  nt;
    int          failures, compares, cyc_n, stamp, s0;
    integer      seed = 32'h7206ADD4;

    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) cyc_n <= cyc_n + 1;
    // The pin is driven by the timer only while it owns it.
    assign shared_w = oe ? pin_o : shr;

    tecc_pins pins (.clk_i(clk_i), .edge_first_o(edge1), .shared_o(shr));
    tecc_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .sel_i(4'hF), .adr_i(adr), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
        .edge_input_first_i(edge1), .shared_port_pin_i(shared_w),
        .shared_port_pin_o(pin_o), .shared_port_pin_oe_o(oe), .irq_o(irq));

    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we === 1'b0) begin
            if (notes.size() == 0) check("unexpected read", 32'h0, 32'h1);
            else begin
                nt = notes.pop_front();
                check("read data", nt.exp & nt.msk, dat_o & nt.msk);
            end
        end
    end

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic [31:0] m);
        int t;
        t = 0;
        if (!w) notes.push_back('{e, m});
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            t++;
        end while (ack_o !== 1'b1 && t < 50);
        if (t >= 50) failures++;
        last  = dat_o;
        stamp = cyc_n;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 32'h0, 32'h0);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        wb(1'b0, a, 32'h0, e, m);
    endtask

    task automatic wait_irq(input logic lvl, input int n);
        int i;
        i = 0;
        while (irq !== lvl && i < n) begin
            @(posedge clk_i);
            i++;
        end
        check("irq", {31'h0, lvl}, {31'h0, irq});
    endtask

    task automatic test_done;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #900000;
        failures++;
        test_done();
    end

    initial begin
        cyc  = 1'b0;
        stb  = 1'b0;
        we   = 1'b0;
        adr  = 4'h0;
        wdat = 32'h0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`TECC_OFS_CTRL, `TECC_CTRL_RST, 32'hFFFFFFFF);
        wr(4'h2, 32'hFFFFFFFF);
        rd(4'h2, 32'h0, 32'hFFFFFFFF);
        check("oe", 32'h0, {31'h0, oe});
        cv = 32'($random(seed)) & 32'hFFFF;
        wr(`TECC_OFS_CCS, cv);
        wr(`TECC_OFS_CTRL, 32'(TECC_FREE));
        rd(`TECC_OFS_CNT, 32'h0, 32'h0);
        c0 = last;
        s0 = stamp;
        repeat (7) @(posedge clk_i);
        rd(`TECC_OFS_CNT, 32'h0, 32'h0);
        check("count step", 32'(stamp - s0), (last - c0) & 32'hFFFF);
        rd(`TECC_OFS_CCS, cv, 32'hFFFF);
        wr(`TECC_OFS_CTRL, 32'(TECC_STOP));
        rd(`TECC_OFS_CNT, 32'h0, 32'hFFFF);
        wr(`TECC_OFS_CCF, 32'h0);
        wr(`TECC_OFS_CTRL, 32'(TECC_FREE) | 32'h100);
        wait_irq(1'b1, 20);
        rd(`TECC_OFS_CTRL, 32'h10000, 32'h10000);
        wr(`TECC_OFS_CTRL, 32'h10100);
        wait_irq(1'b0, 5);
        cv = 32'd8 + (32'($random(seed)) & 32'h1F);
        wr(`TECC_OFS_CCF, cv);
        wr(`TECC_OFS_CTRL, 32'(TECC_CLR_MTCH) | 32'h100);
        wait_irq(1'b1, 100);
        repeat (3 * cv) @(posedge clk_i);
        rd(`TECC_OFS_CNT, 32'h0, 32'h0);
        check("cleared count", 32'h1, {31'h0, last <= cv});
        wr(`TECC_OFS_CTRL, 32'h10000);
        wr(`TECC_OFS_CCF, 32'h1234);
        wr(`TECC_OFS_CTRL, 32'(TECC_FREE));
        pins.pulse(1'b1);
        repeat (6) @(posedge clk_i);
        rd(`TECC_OFS_CCF, 32'h1234, 32'hFFFF);
        wr(`TECC_OFS_CTRL, 32'(TECC_FREE) | 32'h4);
        rd(`TECC_OFS_CNT, 32'h0, 32'h0);
        c1 = last;
        pins.pulse(1'b1);
        repeat (6) @(posedge clk_i);
        rd(`TECC_OFS_CCF, 32'h0, 32'h0);
        check("capture", 32'h1, {31'h0, last[15:0] > c1[15:0]});
        wr(`TECC_OFS_CTRL, 32'(TECC_FREE) | 32'h10);
        @(negedge clk_i);
        check("oe", 32'h1, {31'h0, oe});
        wr(`TECC_OFS_CTRL, 32'(TECC_STOP));
        wr(`TECC_OFS_CTRL, 32'(TECC_FREE) | 32'h8);
        repeat (3) pins.pulse(1'b0);
        repeat (6) @(posedge clk_i);
        rd(`TECC_OFS_CNT, 32'h3, 32'hFFFF);
        wr(`TECC_OFS_CTRL, 32'(TECC_STOP));
        wr(`TECC_OFS_CCF, 32'h0008);
        wr(`TECC_OFS_CTRL, 32'(TECC_FREE) | 32'h200);
        repeat (100) @(posedge clk_i);
        // Raised above the old value, so no restart is owed, yet below the count.
        wr(`TECC_OFS_CCF, 32'h0010);
        wr(`TECC_OFS_CTRL, 32'(TECC_FREE) | 32'h10200);
        repeat (1000) @(posedge clk_i);
        rd(`TECC_OFS_CTRL, 32'h0, 32'h10000);
        wr(`TECC_OFS_CCF, 32'hFFFF);
        wait_irq(1'b1, 70000);
        rd(`TECC_OFS_CTRL, 32'h20000, 32'h20000);
        test_done();
    end
endmodule
`default_nettype wire
